// ==== pkg/tapbs_pkg.sv ====
// shared constants and types for the test port and boundary chain
package tapbs_pkg;
	localparam int CHAIN_LEN = 63;
	localparam int IR_LEN = 4;
	localparam int RESET_ONES = 5;
	localparam logic [3:0] INSN_EXTEST = 4'h0;
	localparam logic [3:0] INSN_SAMPLE = 4'h2;
	localparam logic [3:0] INSN_HIGHZ = 4'h9;
	localparam logic [3:0] INSN_CLAMP = 4'hc;
	localparam logic [3:0] INSN_BYPASS = 4'hf;
	localparam logic [3:0] IR_RESET = INSN_BYPASS;
	localparam logic [1:0] IR_CAPTURE = 2'h1;
	// chain positions from the data-out end (position 1); the struct puts result 5-36, half select 37, long match 38
	localparam int POS_OE_IN = 1;
	localparam int POS_MATCH_SELECT = 2;
	localparam int POS_PATH_SELECT = 3;
	localparam int POS_MATCH_CMD = 4;
	localparam int POS_RESULT_HI = 5;
	localparam int POS_HALF_SELECT = 21;
	localparam int POS_LONG_MATCH = 22;
	localparam int POS_RESULT_LO = 23;
	localparam int POS_DATA_BUS = 39;
	localparam int POS_IF_CLOCK = 55;
	localparam int POS_ADDR = 56;
	localparam int POS_WRITE_EN = 59;
	localparam int POS_PORT_SEL = 60;
	localparam int POS_RESET = 61;
	localparam int POS_INTERRUPT = 62;
	localparam int POS_XFER_ACK = 63;

	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
		ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
		ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} tapbs_state_e;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} tapbs_pins_s;

	// functional pins seen by the chain, grouped in chain order
	typedef struct packed {
		logic output_enable_in;
		logic match_select;
		logic path_circuit_select;
		logic match_command;
		logic [31:0] match_result_bus;
		logic half_select;
		logic long_match_in;
		logic [15:0] control_data_bus;
		logic interface_clock;
		logic [2:0] control_address;
		logic write_enable;
		logic port_select;
		logic reset;
		logic interrupt;
		logic transfer_acknowledge;
	} tapbs_bscan_s;
endpackage

// ==== verilog/tapbs_sync.sv ====
// two-stage synchroniser with a pin default loaded while system reset is low
`timescale 1ns/10ps
module tapbs_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} tapbs_sync_s;
	tapbs_sync_s st_reg, st_next;

	always_comb begin
		st_next.s1 = d_i;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			st_reg <= {INIT, INIT};
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_o = st_reg.s2;
endmodule

// ==== verilog/tapbs_top.sv ====
// test access port controller and 63-cell boundary chain
`timescale 1ns/10ps
module tapbs_top #(
	parameter int CHAIN = tapbs_pkg::CHAIN_LEN
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic test_clk_i,
	input wire logic test_mode_i,
	input wire logic test_data_i,
	input wire logic test_reset_n_i,
	input wire tapbs_pkg::tapbs_bscan_s pins_in_i,
	input wire tapbs_pkg::tapbs_bscan_s core_out_i,
	output tapbs_pkg::tapbs_bscan_s pins_out_o,
	output logic pins_force_z_o,
	output logic test_data_o,
	output logic test_data_oe_o,
	output logic [3:0] state_o
);
	import tapbs_pkg::*;

	typedef struct packed {
		tapbs_state_e state;
		logic [IR_LEN-1:0] ir_shift;
		logic [IR_LEN-1:0] ir;
		logic bypass;
		logic [CHAIN-1:0] bsr_shift;
		logic [CHAIN-1:0] bsr_upd;
		logic tck_d;
		logic tdo;
		logic tdo_oe;
		tapbs_bscan_s pins_out;
		logic force_z;
	} tapbs_top_s;

	tapbs_top_s st_reg, st_next;
	tapbs_pins_s pin_raw, pin_s;
	logic rise, fall, use_bsr, drive_bsr, tdo_bit;

	// the bench holds mode, data and reset high and parks the clock low; reset value matches
	assign pin_raw = '{tck: test_clk_i, tms: test_mode_i, tdi: test_data_i,
		trst_n: test_reset_n_i};

	tapbs_sync #(
		.WIDTH(4),
		.INIT(4'h7)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.d_i(pin_raw),
		.q_o(pin_s)
	);

	function automatic tapbs_state_e next_state(input tapbs_state_e s, input logic m);
		tapbs_state_e n;
		n = s;
		case (s)
			ST_RESET: n = m ? ST_RESET : ST_IDLE;
			ST_IDLE: n = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: n = m ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: n = m ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: n = m ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: n = m ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: n = m ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: n = m ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: n = m ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: n = m ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: n = m ? ST_SEL_DR : ST_IDLE;
			default: n = ST_RESET;
		endcase
		return n;
	endfunction

	// struct msb is position 1, chain bit 0 is position 1: flip the order
	function automatic logic [CHAIN-1:0] rev_chain(input logic [CHAIN-1:0] v);
		logic [CHAIN-1:0] r;
		r = '0;
		for (int i = 0; i < CHAIN; i++) begin
			r[i] = v[CHAIN-1-i];
		end
		return r;
	endfunction

	// edges of the synchronised test clock; the sync stage adds two system cycles
	assign rise = pin_s.tck & ~st_reg.tck_d;
	assign fall = ~pin_s.tck & st_reg.tck_d;

	// extest and sample put the chain on the path, all else the bypass cell
	assign use_bsr = (st_reg.ir == INSN_EXTEST) || (st_reg.ir == INSN_SAMPLE);
	assign drive_bsr = (st_reg.ir == INSN_EXTEST) || (st_reg.ir == INSN_CLAMP);

	always_comb begin
		if (st_reg.state == ST_SHIFT_IR) begin
			tdo_bit = st_reg.ir_shift[0];
		end else if (use_bsr) begin
			tdo_bit = st_reg.bsr_shift[0];
		end else begin
			tdo_bit = st_reg.bypass;
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.tck_d = pin_s.tck;
		if (rise) begin
			st_next.state = next_state(st_reg.state, pin_s.tms);
			case (st_reg.state)
				ST_CAP_IR: begin
					st_next.ir_shift = {{(IR_LEN-2){1'b0}}, IR_CAPTURE};
				end
				ST_SHIFT_IR: begin
					st_next.ir_shift = {pin_s.tdi, st_reg.ir_shift[IR_LEN-1:1]};
				end
				ST_CAP_DR: begin
					st_next.bypass = 1'b0;
					// chain bit 0 is position 1, nearest data-out
					if (use_bsr) begin
						st_next.bsr_shift = rev_chain(pins_in_i);
					end
				end
				ST_SHIFT_DR: begin
					st_next.bypass = pin_s.tdi;
					if (use_bsr) begin
						st_next.bsr_shift = {pin_s.tdi, st_reg.bsr_shift[CHAIN-1:1]};
					end
				end
				default: begin
				end
			endcase
		end
		if (fall) begin
			// controller reset and updates launch on falling edge
			case (st_reg.state)
				ST_RESET: begin
					st_next.ir = IR_RESET;
				end
				ST_UPD_IR: begin
					st_next.ir = st_reg.ir_shift;
				end
				ST_UPD_DR: begin
					// clamp keeps the preloaded values frozen
					if (use_bsr) begin
						st_next.bsr_upd = st_reg.bsr_shift;
					end
				end
				default: begin
				end
			endcase
			st_next.tdo = tdo_bit;
			st_next.tdo_oe = (st_reg.state == ST_SHIFT_IR) ||
				(st_reg.state == ST_SHIFT_DR);
		end
		// test reset wins over clock activity for state, instruction and data-out enable only
		if (!pin_s.trst_n) begin
			st_next.state = ST_RESET;
			st_next.ir = IR_RESET;
			st_next.tdo_oe = 1'b0;
		end
		// only test-side state changes here; core signals pass through in bypass
		st_next.pins_out = (drive_bsr && st_next.state != ST_RESET) ?
			tapbs_bscan_s'(rev_chain(st_reg.bsr_upd)) : core_out_i;
		st_next.force_z = (st_reg.ir == INSN_HIGHZ) && (st_reg.state != ST_RESET);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			st_reg <= '{state: ST_RESET, ir: IR_RESET, ir_shift: '0, bypass: 1'b0,
				bsr_shift: '0, bsr_upd: '0, tck_d: 1'b0, tdo: 1'b0, tdo_oe: 1'b0,
				pins_out: '0, force_z: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign pins_out_o = st_reg.pins_out;
	assign pins_force_z_o = st_reg.force_z;
	assign test_data_o = st_reg.tdo;
	assign test_data_oe_o = st_reg.tdo_oe;
	assign state_o = st_reg.state;
endmodule

// ==== tb/tapbs_host.sv ====
// behavioural boundary-scan controller driving the test port pins
`timescale 1ns/10ps
module tapbs_host (
	input wire logic clk_sys_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	// unused port: clock parked low, mode and data held high
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end
	// one 320 ns test clock period; pins move only while the clock is low
	task automatic step(input logic m, input logic d);
		tms_o <= m;
		tdi_o <= d;
		repeat (4) @(posedge clk_sys_i);
		tck_o <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		tck_o <= 1'b0;
	endtask
endmodule

// ==== tb/tapbs_top_assertions.sv ====
// concurrent checks on the test port and chain outputs
`timescale 1ns/10ps
module tapbs_top_assertions #(
	parameter int CHAIN = tapbs_pkg::CHAIN_LEN
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic test_clk_i,
	input wire logic test_mode_i,
	input wire logic test_data_i,
	input wire logic test_reset_n_i,
	input wire tapbs_pkg::tapbs_bscan_s pins_in_i,
	input wire tapbs_pkg::tapbs_bscan_s core_out_i,
	input wire tapbs_pkg::tapbs_bscan_s pins_out_o,
	input wire logic pins_force_z_o,
	input wire logic test_data_o,
	input wire logic test_data_oe_o,
	input wire logic [3:0] state_o
);
	import tapbs_pkg::*;
	logic tck_q;
	logic [2:0] ones_q;
	// saturating count of test clock rises with mode select high
	always_ff @(posedge clk_sys_i) begin
		tck_q <= test_clk_i;
		if (!rstn_i || !test_reset_n_i || (test_clk_i && !tck_q && !test_mode_i)) begin
			ones_q <= 3'h0;
		end else if (test_clk_i && !tck_q && ones_q != 3'h7) begin
			ones_q <= ones_q + 3'h1;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	oe_shift_a: assert property (
		$rose(test_data_oe_o) |-> state_o inside {ST_SHIFT_DR, ST_SHIFT_IR}) else $error("oe bad");
	tdo_fall_a: assert property (
		$changed(test_data_o) |-> $past(!test_clk_i)) else $error("tdo moved");
	state_rise_a: assert property (
		$changed(state_o) && test_reset_n_i && $past(test_reset_n_i, 4) |-> $past(test_clk_i))
		else $error("state moved");
	trst_force_a: assert property (
		!test_reset_n_i [*5] |-> state_o == ST_RESET) else $error("trst ignored");
	five_ones_a: assert property (
		ones_q > 3'h4 |-> ##[0:6] state_o == ST_RESET) else $error("no reset");
	upd_ir_a: assert property (
		$changed(state_o) && $past(state_o) == ST_UPD_IR |-> state_o inside {ST_IDLE, ST_SEL_DR})
		else $error("bad arc");
	highz_rst_a: assert property (
		state_o == ST_RESET [*3] |-> !pins_force_z_o) else $error("highz in reset");
	func_pass_a: assert property (
		state_o == ST_RESET [*3] |-> pins_out_o == $past(core_out_i)) else $error("pins held");
	cover property (state_o == ST_SHIFT_DR && test_data_oe_o);
	cover property (pins_force_z_o);
	cover property (ones_q == 3'h5);
endmodule
bind tapbs_top tapbs_top_assertions #(.CHAIN(CHAIN)) u_chk (.*);

// ==== tb/tapbs_top_bench.sv ====
// self-checking bench: scans through the test port, checks pins and data-out
`timescale 1ns/10ps
module tapbs_top_bench;
	import tapbs_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic test_reset_n_i = 1'b1;
	logic test_clk_i, test_mode_i, test_data_i, pins_force_z_o, test_data_o, test_data_oe_o;
	logic [3:0] state_o;
	tapbs_bscan_s pins_in_i = '0;
	tapbs_bscan_s core_out_i = '0;
	tapbs_bscan_s pins_out_o;
	logic [62:0] pat, rev_in, rev_pat;
	logic [3:0] codes[3] = '{INSN_HIGHZ, INSN_CLAMP, INSN_BYPASS};
	logic q[$];
	int num_errors = 0;
	int n_checks = 0;
	initial forever #20 clk_sys_i = ~clk_sys_i;
	tapbs_host i_host (.clk_sys_i(clk_sys_i), .tck_o(test_clk_i), .tms_o(test_mode_i),
		.tdi_o(test_data_i));
	tapbs_top i_dut (.*);
	task automatic chk(input string what, input logic [62:0] seen, input logic [62:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// idle to shift state, n bits with notes queued, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [127:0] d, input logic [127:0] e);
		i_host.step(1'b1, 1'b1);
		if (ir) i_host.step(1'b1, 1'b1);
		repeat (2) i_host.step(1'b0, 1'b1);
		for (int i = 0; i < n; i++) begin
			q.push_back(e[i]);
			i_host.step(i == n - 1, d[i]);
		end
		i_host.step(1'b1, 1'b1);
		i_host.step(1'b0, 1'b1);
		repeat (8) @(posedge clk_sys_i);
	endtask
	// capture pattern 0001 leaves first on every instruction load
	task automatic load(input logic [3:0] code);
		scan(1'b1, 4, 128'(code), 128'h1);
	endtask
	always @(posedge test_clk_i) begin
		if (test_data_oe_o === 1'b1) begin
			chk("tdo", test_data_o, q.size() ? q.pop_front() : 1'bx);
		end
	end
	initial begin
		#500us;
		num_errors++;
		summarize();
	end
	initial begin
		void'($urandom(32'h908d4b26));
		repeat (16) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		pins_in_i <= 63'({$urandom(), $urandom()});
		core_out_i <= 63'({$urandom(), $urandom()});
		pat = 63'({$urandom(), $urandom()});
		repeat (4) @(posedge clk_sys_i);
		rev_in = {<<{pins_in_i}};
		rev_pat = {<<{pat}};
		// leave the reset state for idle before the first scan
		i_host.step(1'b0, 1'b1);
		load(INSN_SAMPLE);
		// first 63 out are the capture from the data-out end, then data-in echoes
		scan(1'b0, 126, {2'h0, pat, ~pat}, {2'h0, ~pat, rev_in});
		load(INSN_EXTEST);
		chk("extest", pins_out_o, rev_pat);
		foreach (codes[k]) begin
			load(codes[k]);
			chk("highz", pins_force_z_o, codes[k] == INSN_HIGHZ);
			chk("drive", pins_out_o, codes[k] == INSN_CLAMP ? rev_pat : core_out_i);
			scan(1'b0, 2, 128'h1, 128'h2);
		end
		i_host.step(1'b1, 1'b1);
		repeat (2) i_host.step(1'b0, 1'b1);
		q.push_back(1'b0);
		repeat (4) i_host.step(1'b1, 1'b1);
		repeat (8) @(posedge clk_sys_i);
		chk("state", state_o, ST_SEL_IR);
		i_host.step(1'b1, 1'b1);
		repeat (8) @(posedge clk_sys_i);
		chk("state", state_o, ST_RESET);
		i_host.step(1'b0, 1'b1);
		i_host.step(1'b1, 1'b1);
		repeat (2) i_host.step(1'b0, 1'b1);
		test_reset_n_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		chk("state", state_o, ST_RESET);
		test_reset_n_i <= 1'b1;
		chk("notes", q.size(), 0);
		summarize();
	end
endmodule
